// ===== sac_defines.svh
// Purpose: Shared constants for the spectrum averaging capture block
// Assumes: One 40 MHz clock, synchronous active-high reset
// Notes:   Sizes are fixed; record length is scaled down by the span select
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// ****************************************
// Widths and sizes
// ****************************************
`define SAC_SAMPLE_W 16
`define SAC_ADDR_W 6
`define SAC_REC_MAX 64
`define SAC_BANKS 2
`define SAC_FIFO_DEPTH 8
`define SAC_AVG_W 8
`define SAC_SPAN_W 2
`define SAC_LIN_ACC_W 24
`define SAC_PWR_ACC_W 40
`define SAC_RMS_W 20

// ****************************************
// Reset values
// ****************************************
`define SAC_CNT_RST 8'h00
`define SAC_IDX_RST 6'h00

`endif

// ===== sac_pkg.sv
// Purpose: Types for the spectrum averaging capture block
// Assumes: Nothing beyond the defines header
// Notes:   Constants live in sac_defines.svh
package sac_pkg;
	typedef enum logic [1:0] {
		S_IDLE,
		S_WAIT_TRIG,
		S_FILL,
		S_STALL
	} capture_state_t;
endpackage

// ===== sac_stream_if.sv
// Purpose: Valid/ready word stream between the capture logic and its FIFO
// Assumes: Word taken on any rising edge with valid and ready both high
// Notes:   src drives the words, snk accepts them
interface sac_stream_if #(parameter int WIDTH = 16);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ===== sac_fifo.sv
// Purpose: Sample FIFO in front of the time record buffer
// Assumes: Synchronous reset, single clock
// Notes:   Ready on the write side falls only when full, so a stalled drain
//          pushes back to the sample source
module sac_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	sac_stream_if.snk wr,
	sac_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
	assign rd.valid = (cnt_r != '0);
	assign rd.data = mem[rp_r];

	always_comb
	begin
		push = wr.valid & wr.ready;
		pop = rd.valid & rd.ready;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		if (push)
		begin
			wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + AW'(1);
		end
		if (pop)
		begin
			rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + AW'(1);
		end
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (push)
		begin
			mem[wp_r] <= wr.data;
		end
	end
endmodule

// ===== spectrum_averaging_capture.sv
// Purpose: Sample capture, double time record buffer and averaging
// Assumes: Samples synchronous to i_ref_clk; engine holds i_eng_busy while
//          it transforms and raises it within a few cycles of o_rec_start
// Notes:   Transform itself lives outside; it reads the handed record and
//          returns magnitudes for power averaging
`include "sac_defines.svh"
module spectrum_averaging_capture import sac_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_restart,
	input wire logic i_linear_mode,
	input wire logic [`SAC_AVG_W-1:0] i_avg_count,
	input wire logic [`SAC_SPAN_W-1:0] i_span_sel,
	input wire logic i_sample_valid,
	input wire logic [`SAC_SAMPLE_W-1:0] i_sample,
	output logic o_sample_ready,
	input wire logic i_trigger,
	output logic o_rec_start,
	output logic o_rec_bank,
	input wire logic i_eng_busy,
	input wire logic [`SAC_ADDR_W-1:0] i_eng_addr,
	output logic [`SAC_SAMPLE_W-1:0] o_eng_data,
	input wire logic i_mag_valid,
	input wire logic i_mag_last,
	input wire logic [`SAC_ADDR_W-1:0] i_mag_addr,
	input wire logic signed [`SAC_SAMPLE_W-1:0] i_mag_re,
	input wire logic signed [`SAC_SAMPLE_W-1:0] i_mag_im,
	input wire logic [`SAC_ADDR_W-1:0] i_res_addr,
	output logic [`SAC_SAMPLE_W-1:0] o_lin_avg,
	output logic [`SAC_RMS_W-1:0] o_rms_avg,
	output logic o_avg_done,
	output logic o_non_real_time,
	output logic o_acquiring
);
	// ****************************************
	// Storage
	// ****************************************
	logic [`SAC_SAMPLE_W-1:0] rec_mem [`SAC_BANKS*`SAC_REC_MAX];
	logic signed [`SAC_LIN_ACC_W-1:0] lin_acc [`SAC_REC_MAX];
	logic [`SAC_PWR_ACC_W-1:0] pwr_acc [`SAC_REC_MAX];

	capture_state_t state_r, state_nxt;
	logic bank_r, bank_nxt;
	logic linear_r, linear_nxt;
	logic [`SAC_SPAN_W-1:0] span_r, span_nxt;
	logic [`SAC_ADDR_W-1:0] wr_idx_r, wr_idx_nxt;
	logic [`SAC_ADDR_W:0] in_cnt_r, in_cnt_nxt;
	logic [`SAC_AVG_W-1:0] avg_cnt_r, avg_cnt_nxt;
	logic [`SAC_AVG_W-1:0] target_r, target_nxt;
	logic done_r, done_nxt;
	logic nrt_r, nrt_nxt;
	logic start_r, start_nxt;
	logic [`SAC_SAMPLE_W-1:0] eng_data_r;
	logic [`SAC_SAMPLE_W-1:0] lin_avg_r, lin_avg_nxt;
	logic [`SAC_RMS_W-1:0] rms_r, rms_nxt;

	logic [`SAC_ADDR_W:0] rec_len;
	logic [`SAC_ADDR_W-1:0] last_idx;
	logic in_open, pop, rec_full, handover, lin_we, pwr_we;
	logic signed [`SAC_LIN_ACC_W-1:0] lin_sum;
	logic [`SAC_PWR_ACC_W-1:0] pwr_sum;
	logic [31:0] mag_sq;

	sac_stream_if #(.WIDTH(`SAC_SAMPLE_W)) fifo_in ();
	sac_stream_if #(.WIDTH(`SAC_SAMPLE_W)) fifo_out ();

	// Integer square root, one bit per step from the top
	function automatic logic [`SAC_RMS_W-1:0] isqrt(input logic [`SAC_PWR_ACC_W-1:0] v);
		logic [`SAC_RMS_W-1:0] root;
		logic [`SAC_RMS_W-1:0] trial;
		root = '0;
		for (int i = `SAC_RMS_W - 1; i >= 0; i--)
		begin
			trial = root | (`SAC_RMS_W'(1) << i);
			if ((`SAC_PWR_ACC_W'(trial) * `SAC_PWR_ACC_W'(trial)) <= v)
			begin
				root = trial;
			end
		end
		return root;
	endfunction

	// ****************************************
	// Input path through the FIFO
	// ****************************************
	// Wider span, shorter record
	assign rec_len = (`SAC_ADDR_W+1)'(`SAC_REC_MAX) >> span_r;
	assign last_idx = `SAC_ADDR_W'(rec_len - (`SAC_ADDR_W+1)'(1));

	// Linear records close at their length so the next one waits for a trigger;
	// power records keep streaming into the FIFO until it backs up
	assign in_open = ((state_r == S_FILL) || (state_r == S_STALL))
		&& (!linear_r || (in_cnt_r < rec_len));
	assign fifo_in.valid = i_sample_valid & in_open;
	assign fifo_in.data = i_sample;
	// Ready stays high while waiting for a trigger: those samples are dropped
	assign o_sample_ready = (state_r == S_WAIT_TRIG) | (in_open & fifo_in.ready);

	// Drain halts in a stall, so the FIFO fills and back-pressure stops capture
	assign fifo_out.ready = (state_r == S_FILL);
	assign pop = fifo_out.valid & fifo_out.ready;
	assign rec_full = pop && (wr_idx_r == last_idx);

	sac_fifo #(
		.WIDTH(`SAC_SAMPLE_W),
		.DEPTH(`SAC_FIFO_DEPTH)
	) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.wr(fifo_in),
		.rd(fifo_out)
	);

	// ****************************************
	// Capture control
	// ****************************************
	always_comb
	begin
		state_nxt = state_r;
		bank_nxt = bank_r;
		linear_nxt = linear_r;
		span_nxt = span_r;
		wr_idx_nxt = wr_idx_r;
		in_cnt_nxt = in_cnt_r;
		avg_cnt_nxt = avg_cnt_r;
		target_nxt = target_r;
		done_nxt = done_r;
		nrt_nxt = nrt_r;
		start_nxt = 1'b0;
		handover = 1'b0;
		if (fifo_in.valid && fifo_in.ready)
		begin
			in_cnt_nxt = (in_cnt_r + (`SAC_ADDR_W+1)'(1) >= rec_len && !linear_r)
				? '0 : in_cnt_r + (`SAC_ADDR_W+1)'(1);
		end
		if (pop)
		begin
			wr_idx_nxt = rec_full ? `SAC_IDX_RST : wr_idx_r + `SAC_ADDR_W'(1);
		end
		case (state_r)
			S_IDLE:
			begin
			end
			S_WAIT_TRIG:
			begin
				if (i_trigger)
				begin
					state_nxt = S_FILL;
					in_cnt_nxt = '0;
				end
			end
			S_FILL:
			begin
				if (rec_full)
				begin
					if (!i_eng_busy)
					begin
						handover = 1'b1;
					end
					else
					begin
						state_nxt = S_STALL;
						nrt_nxt = 1'b1;
					end
				end
			end
			S_STALL:
			begin
				if (!i_eng_busy)
				begin
					handover = 1'b1;
				end
			end
			default:
			begin
				state_nxt = S_IDLE;
			end
		endcase
		if (handover)
		begin
			// Hand the full bank over and fill the other one meanwhile
			start_nxt = 1'b1;
			bank_nxt = ~bank_r;
			state_nxt = linear_r ? S_WAIT_TRIG : S_FILL;
			if (linear_r && !done_r)
			begin
				avg_cnt_nxt = avg_cnt_r + `SAC_AVG_W'(1);
			end
		end
		if (!linear_r && i_mag_valid && i_mag_last && !done_r)
		begin
			avg_cnt_nxt = avg_cnt_r + `SAC_AVG_W'(1);
		end
		if (avg_cnt_nxt == target_r && target_r != '0 && avg_cnt_nxt != avg_cnt_r)
		begin
			done_nxt = 1'b1;
		end
		if (done_r && handover)
		begin
			state_nxt = S_IDLE;
		end
		if (i_restart)
		begin
			state_nxt = i_linear_mode ? S_WAIT_TRIG : S_FILL;
			linear_nxt = i_linear_mode;
			span_nxt = i_span_sel;
			target_nxt = i_avg_count;
			avg_cnt_nxt = `SAC_CNT_RST;
			done_nxt = 1'b0;
			nrt_nxt = 1'b0;
			wr_idx_nxt = `SAC_IDX_RST;
			in_cnt_nxt = '0;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			state_r <= S_IDLE;
			bank_r <= 1'b0;
			linear_r <= 1'b0;
			span_r <= '0;
			wr_idx_r <= `SAC_IDX_RST;
			in_cnt_r <= '0;
			avg_cnt_r <= `SAC_CNT_RST;
			target_r <= `SAC_CNT_RST;
			done_r <= 1'b0;
			nrt_r <= 1'b0;
			start_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			bank_r <= bank_nxt;
			linear_r <= linear_nxt;
			span_r <= span_nxt;
			wr_idx_r <= wr_idx_nxt;
			in_cnt_r <= in_cnt_nxt;
			avg_cnt_r <= avg_cnt_nxt;
			target_r <= target_nxt;
			done_r <= done_nxt;
			nrt_r <= nrt_nxt;
			start_r <= start_nxt;
		end
	end

	// ****************************************
	// Record buffer and accumulators
	// ****************************************
	// The first record after a restart overwrites, later ones add
	always_comb
	begin
		lin_we = pop && linear_r && !done_r;
		pwr_we = i_mag_valid && !linear_r && !done_r;
		lin_sum = (avg_cnt_r == '0) ? `SAC_LIN_ACC_W'(signed'(fifo_out.data))
			: lin_acc[wr_idx_r] + `SAC_LIN_ACC_W'(signed'(fifo_out.data));
		// Magnitude squared only: the phase never enters the sum
		mag_sq = 32'(i_mag_re) * 32'(i_mag_re) + 32'(i_mag_im) * 32'(i_mag_im);
		pwr_sum = ((avg_cnt_r == '0) ? '0 : pwr_acc[i_mag_addr])
			+ `SAC_PWR_ACC_W'(mag_sq);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (pop)
		begin
			rec_mem[{bank_r, wr_idx_r}] <= fifo_out.data;
		end
		if (lin_we)
		begin
			lin_acc[wr_idx_r] <= lin_sum;
		end
		if (pwr_we)
		begin
			pwr_acc[i_mag_addr] <= pwr_sum;
		end
		// Engine reads the bank last handed over
		eng_data_r <= rec_mem[{~bank_r, i_eng_addr}];
	end

	// ****************************************
	// Averaged results
	// ****************************************
	// Division and root are combinational on the read path; slow but small
	always_comb
	begin
		lin_avg_nxt = '0;
		rms_nxt = '0;
		if (avg_cnt_r != '0)
		begin
			lin_avg_nxt = `SAC_SAMPLE_W'(lin_acc[i_res_addr]
				/ signed'(`SAC_LIN_ACC_W'(avg_cnt_r)));
			rms_nxt = isqrt(pwr_acc[i_res_addr] / `SAC_PWR_ACC_W'(avg_cnt_r));
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			lin_avg_r <= 16'h0000;
			rms_r <= '0;
		end
		else
		begin
			lin_avg_r <= lin_avg_nxt;
			rms_r <= rms_nxt;
		end
	end

	assign o_eng_data = eng_data_r;
	assign o_rec_start = start_r;
	assign o_rec_bank = ~bank_r;
	assign o_lin_avg = lin_avg_r;
	assign o_rms_avg = rms_r;
	assign o_avg_done = done_r;
	assign o_non_real_time = nrt_r;
	assign o_acquiring = o_sample_ready;
endmodule

// ===== sac_assertions.sv
// Purpose: Port checks for spectrum_averaging_capture
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every instance of the top module
// ************************************************
// Checker
// ************************************************
module sac_assertions (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_restart,
	input wire logic i_eng_busy,
	input wire logic i_sample_valid,
	input wire logic o_sample_ready,
	input wire logic o_acquiring,
	input wire logic o_rec_start,
	input wire logic o_rec_bank,
	input wire logic o_avg_done,
	input wire logic o_non_real_time
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	// Stall entered and source keeps pushing while the engine stays busy
	sequence s_stall;
		$rose(o_non_real_time) && i_eng_busy
			##1 (i_eng_busy && i_sample_valid && !i_restart) [*8];
	endsequence
	property p_gap; o_rec_start |=> !o_rec_start [*7]; endproperty
	a_gap: assert property (p_gap) else $error("handovers too close");
	property p_free; o_rec_start |-> !$past(i_eng_busy); endproperty
	a_free: assert property (p_free) else $error("handover to busy engine");
	property p_bank; $changed(o_rec_bank) |-> o_rec_start || $past(i_restart); endproperty
	a_bank: assert property (p_bank) else $error("bank moved without handover");
	property p_nrt; o_non_real_time && !i_restart |=> o_non_real_time; endproperty
	a_nrt: assert property (p_nrt) else $error("stall flag lost");
	property p_clr; i_restart |=> !o_avg_done && !o_non_real_time; endproperty
	a_clr: assert property (p_clr) else $error("restart left flags set");
	property p_done; o_avg_done && !i_restart |=> o_avg_done; endproperty
	a_done: assert property (p_done) else $error("done flag lost");
	// In real time a handover never pauses capture until the average is done
	property p_acq;
		o_rec_start && !o_non_real_time && !$past(o_avg_done) && !$past(i_restart)
			|-> o_acquiring;
	endproperty
	a_acq: assert property (p_acq) else $error("capture paused in real time");
	property p_halt; s_stall |=> !o_sample_ready; endproperty
	a_halt: assert property (p_halt) else $error("capture not halted");
endmodule

bind spectrum_averaging_capture sac_assertions chk (.i_ref_clk, .i_rst, .i_restart,
	.i_eng_busy, .i_sample_valid, .o_sample_ready, .o_acquiring, .o_rec_start,
	.o_rec_bank, .o_avg_done, .o_non_real_time);

// ===== sac_engine_model.sv
// Purpose: Transform engine stand-in at the far side of the record buffer
// Assumes: Busy rises one cycle after a handover and lasts i_busy_len cycles
// Notes: Phase alternates per record, so a vector average would differ
`include "sac_defines.svh"
// ************************************************
// Engine model
// ************************************************
module sac_engine_model (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_rec_start,
	input wire logic [`SAC_SAMPLE_W-1:0] i_eng_data,
	input wire logic [7:0] i_busy_len,
	input wire logic [6:0] i_len,
	output logic o_busy,
	output logic [`SAC_ADDR_W-1:0] o_addr,
	output logic o_mag_valid,
	output logic o_mag_last,
	output logic [`SAC_ADDR_W-1:0] o_mag_addr,
	output logic signed [`SAC_SAMPLE_W-1:0] o_mag_re,
	output logic signed [`SAC_SAMPLE_W-1:0] o_mag_im
);
	logic [7:0] left;
	logic [`SAC_ADDR_W-1:0] prev;
	logic pv;
	logic odd;
	logic [`SAC_SAMPLE_W-1:0] cap [64];
	always @(posedge i_ref_clk)
	begin
		o_mag_valid <= 1'h0;
		o_mag_last <= 1'h0;
		// Idle bins toggle so stale values never look valid
		o_mag_re <= ~o_mag_re;
		o_mag_im <= ~o_mag_im;
		pv <= o_busy && o_addr < i_len;
		prev <= o_addr;
		o_addr <= o_addr + 6'h01;
		if (pv)
		begin
			cap[prev] <= i_eng_data;
			o_mag_valid <= 1'h1;
			o_mag_addr <= prev;
			o_mag_re <= 16'(odd ? -5 * int'(prev) : 3 * int'(prev));
			o_mag_im <= 16'(odd ? 0 : 4 * int'(prev));
			o_mag_last <= prev == i_len - 1;
			odd <= odd ^ (prev == i_len - 1);
		end
		if (i_rst)
		begin
			left <= 8'h00;
			o_busy <= 1'h0;
			odd <= 1'h0;
			pv <= 1'h0;
			o_mag_re <= 16'h5555;
			o_mag_im <= 16'h3333;
		end
		else if (i_rec_start)
		begin
			left <= i_busy_len;
			o_busy <= 1'h1;
			o_addr <= 6'h00;
		end
		else if (left != 8'h00)
		begin
			left <= left - 8'h01;
			o_busy <= left > 1;
		end
	end
endmodule

// ===== testbench.sv
// Purpose: Self-checking bench for spectrum_averaging_capture
// Assumes: Engine model answers each handover
// Notes: Span 3 gives eight-word records for short runs
// ************************************************
// Bench
// ************************************************
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk = 0, i_rst = 1, i_restart = 0, i_linear_mode = 0, i_trigger = 0;
	logic i_sample_valid = 0;
	logic [7:0] i_avg_count = 0, busy_len = 0;
	logic [1:0] i_span_sel = 0;
	logic [6:0] len = 8;
	logic [15:0] i_sample = 0;
	logic [5:0] i_res_addr = 0;
	logic o_sample_ready, o_rec_start, o_rec_bank, i_eng_busy, i_mag_valid, i_mag_last;
	logic o_avg_done, o_non_real_time, o_acquiring;
	logic [5:0] i_eng_addr, i_mag_addr;
	logic [15:0] o_eng_data, o_lin_avg;
	logic signed [15:0] i_mag_re, i_mag_im;
	logic [19:0] o_rms_avg;
	int miscompares = 0, n_checks = 0, cycles = 0;
	spectrum_averaging_capture dut (.i_ref_clk, .i_rst, .i_restart, .i_linear_mode,
		.i_avg_count, .i_span_sel, .i_sample_valid, .i_sample, .o_sample_ready, .i_trigger,
		.o_rec_start, .o_rec_bank, .i_eng_busy, .i_eng_addr, .o_eng_data, .i_mag_valid,
		.i_mag_last, .i_mag_addr, .i_mag_re, .i_mag_im, .i_res_addr, .o_lin_avg, .o_rms_avg,
		.o_avg_done, .o_non_real_time, .o_acquiring);
	sac_engine_model eng (.i_ref_clk, .i_rst, .i_rec_start(o_rec_start),
		.i_eng_data(o_eng_data), .i_busy_len(busy_len), .i_len(len), .o_busy(i_eng_busy),
		.o_addr(i_eng_addr), .o_mag_valid(i_mag_valid), .o_mag_last(i_mag_last),
		.o_mag_addr(i_mag_addr), .o_mag_re(i_mag_re), .o_mag_im(i_mag_im));
	always #12.5 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			miscompares++;
			finish_test;
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	task mid;
		@(negedge i_ref_clk);
	endtask
	task automatic idle;
		for (int k = 0; k < 100 && i_eng_busy; k++)
			tick(1);
		tick(1);
	endtask
	task automatic start(input logic lin, input logic [7:0] cnt, input int span, input int bl);
		idle;
		i_linear_mode <= lin;
		i_avg_count <= cnt;
		i_span_sel <= 2'(span);
		busy_len <= 8'(bl);
		len <= 7'(64 >> span);
		i_restart <= 1;
		tick(1);
		i_restart <= 0;
		mid;
	endtask
	task automatic read_res(input int a);
		tick(1);
		i_res_addr <= 6'(a);
		tick(1);
		mid;
	endtask
	task automatic t_linear;
		start(1, 8'h02, 3, 12);
		tick(1);
		i_sample_valid <= 1;
		i_sample <= 16'hffff;
		tick(4);
		for (int r = 0; r < 2; r++)
		begin
			tick(4);
			idle;
			i_trigger <= 1;
			tick(1);
			i_trigger <= 0;
			for (int j = 0; j < 8; j++)
			begin
				i_sample <= 16'(100 * r + 3 * j);
				mid;
				check("ready", o_sample_ready, 1);
				tick(1);
			end
			i_sample <= 16'hffff;
		end
		for (int k = 0; k < 200 && !o_avg_done; k++)
			mid;
		check("done", o_avg_done, 1);
		check("nrt", o_non_real_time, 0);
		tick(3);
		idle;
		for (int k = 0; k < 8; k++)
		begin
			check("record", eng.cap[k], 100 + 3 * k);
			read_res(k);
			check("lin avg", o_lin_avg, 50 + 3 * k);
		end
		$display("linear test done");
	endtask
	task automatic t_stall;
		start(0, 8'h00, 3, 40);
		for (int k = 0; k < 300 && !o_non_real_time; k++)
			mid;
		check("nrt", o_non_real_time, 1);
		repeat (12) mid;
		check("halt", o_sample_ready, 0);
		check("acquiring", o_acquiring, 0);
		for (int k = 0; k < 100 && !o_rec_start; k++)
			mid;
		check("handover", o_rec_start, 1);
		repeat (2) mid;
		check("resume", o_sample_ready, 1);
		check("acquiring", o_acquiring, 1);
		$display("stall test done");
	endtask
	task automatic t_power;
		start(0, 8'h02, 3, 10);
		check("nrt clear", o_non_real_time, 0);
		for (int k = 0; k < 400 && !o_avg_done; k++)
			mid;
		check("done", o_avg_done, 1);
		for (int b = 0; b < 8; b++)
		begin
			read_res(b);
			check("rms", o_rms_avg, 5 * b);
		end
		$display("power test done");
	endtask
	task automatic t_span;
		int n;
		for (int s = 0; s < 4; s++)
		begin
			start(0, 8'h00, s, 4);
			for (int k = 0; k < 200 && !o_rec_start; k++)
				mid;
			mid;
			for (n = 1; n < 200 && !o_rec_start; n++)
				mid;
			check("record length", n, 64 >> s);
		end
		$display("span test done");
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		tick(5);
		i_rst <= 0;
		mid;
		check("bank", o_rec_bank, 1);
		t_linear;
		t_stall;
		t_power;
		t_span;
		finish_test;
	end
endmodule
